// >>> design/qsram_array.sv
`timescale 1ns/1ps
`default_nettype none
`include "qsram_params.svh"
// ==========================================================
// two-bank storage with byte lanes
module qsram_array #(
    parameter int AW = `QSRAM_ADDR_W,
    parameter int DW = `QSRAM_WORD_W,
    parameter int BW = `QSRAM_BYTE_W,
    parameter int NL = `QSRAM_LANES
) (
    input  wire logic    clk,
    qsram_wr_if.dst      wr,
    input  wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0]      rd_word0,
    output logic [DW-1:0]      rd_word1
);
    logic [DW-1:0] bank0 [0:(1<<AW)-1];
    logic [DW-1:0] bank1 [0:(1<<AW)-1];

    assign rd_word0 = bank0[rd_addr];
    assign rd_word1 = bank1[rd_addr];

    // ==========================================================
    // lane masked commit
    always_ff @(posedge clk) begin
        for (int l = 0; l < NL; l++) begin
            if (wr.commit && !wr.lane0_n[l]) begin
                bank0[wr.addr][l*BW +: BW] <= wr.word0[l*BW +: BW];
            end
            if (wr.commit && !wr.lane1_n[l]) begin
                bank1[wr.addr][l*BW +: BW] <= wr.word1[l*BW +: BW];
            end
        end
    end
endmodule
`default_nettype wire

// >>> design/qsram_params.svh
`ifndef QSRAM_PARAMS_SVH
`define QSRAM_PARAMS_SVH

// ==========================================================
// sizes and codes
`define QSRAM_WORD_W        18
`define QSRAM_BYTE_W        9
`define QSRAM_LANES         2
`define QSRAM_ADDR_W        19
`define QSRAM_CAL_PERIOD    1024
`define QSRAM_CLK_MHZ       25
`define QSRAM_DLL_MIN_MHZ   80
`define QSRAM_DLL_MAX_NS    30
`define QSRAM_DLL_MAX_CYC   ((`QSRAM_DLL_MAX_NS * `QSRAM_CLK_MHZ) / 1000)
`define QSRAM_CNT_W         10
`define QSRAM_SYNC_STAGES   2

`endif

// >>> design/qsram_pkg.sv
`default_nettype none
package qsram_pkg;
    // ==========================================================
    // read pipeline states
    typedef enum logic [3:0] {
        QSRAM_RD_IDLE  = 4'b0001,
        QSRAM_RD_WAIT  = 4'b0010,
        QSRAM_RD_WORD0 = 4'b0100,
        QSRAM_RD_WORD1 = 4'b1000
    } qsram_rd_state_type;
endpackage
`default_nettype wire

// >>> design/qsram_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "qsram_params.svh"
module qsram_port
    import qsram_pkg::*;
#(
    parameter int AW  = `QSRAM_ADDR_W,
    parameter int DW  = `QSRAM_WORD_W,
    parameter int NL  = `QSRAM_LANES,
    parameter int CAL = `QSRAM_CAL_PERIOD
) (
    input  wire logic          clk,
    input  wire logic          reset_n,
    input  wire logic          link_clk,
    input  wire logic          link_clk_n,
    input  wire logic          output_timing_ref,
    input  wire logic          output_timing_ref_n,
    input  wire logic          read_port_select_n,
    input  wire logic          write_port_select_n,
    input  wire logic [AW-1:0] address_in,
    input  wire logic [DW-1:0] write_value_in,
    input  wire logic [NL-1:0] byte_write_select_n,
    input  wire logic          loop_disable_n,
    output logic [DW-1:0]      read_data_out,
    output logic               read_data_oe_n,
    output logic               returned_strobe,
    output logic               returned_strobe_n,
    output logic               single_clock_mode,
    output logic               loop_active,
    output logic               impedance_update
);
    import qsram_pkg::*;

    // ==========================================================
    // link side: capture on the strobe pair
    // link_clk is capture_strobe_pos, link_clk_n is capture_strobe_neg
    logic          lk_wr_pend_reg;
    logic [DW-1:0] lk_word0_reg;
    logic [NL-1:0] lk_lane0_reg;
    logic          lk_rd_tog_reg;
    logic [AW-1:0] lk_rd_addr_reg;
    logic          lk_wr_tog_reg;
    logic [AW-1:0] lk_wr_addr_reg;
    logic [DW-1:0] lk_w0_reg;
    logic [DW-1:0] lk_w1_reg;
    logic [NL-1:0] lk_l0_reg;
    logic [NL-1:0] lk_l1_reg;

    wire rd_start = !read_port_select_n;
    wire wr_start = !write_port_select_n;

    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            lk_wr_pend_reg <= 1'b0;
            lk_word0_reg   <= '0;
            lk_lane0_reg   <= '1;
            lk_rd_tog_reg  <= 1'b0;
            lk_rd_addr_reg <= '0;
        end else begin
            lk_wr_pend_reg <= wr_start;
            if (wr_start) begin
                lk_word0_reg <= write_value_in;
                lk_lane0_reg <= byte_write_select_n;
            end
            if (rd_start) begin
                lk_rd_addr_reg <= address_in;
                lk_rd_tog_reg  <= !lk_rd_tog_reg;
            end
        end
    end

    // second half of a write; commit only if one is pending
    always_ff @(posedge link_clk_n or negedge reset_n) begin
        if (!reset_n) begin
            lk_wr_tog_reg  <= 1'b0;
            lk_wr_addr_reg <= '0;
            lk_w0_reg      <= '0;
            lk_w1_reg      <= '0;
            lk_l0_reg      <= '1;
            lk_l1_reg      <= '1;
        end else if (lk_wr_pend_reg) begin
            lk_wr_addr_reg <= address_in;
            lk_w0_reg      <= lk_word0_reg;
            lk_w1_reg      <= write_value_in;
            lk_l0_reg      <= lk_lane0_reg;
            lk_l1_reg      <= byte_write_select_n;
            lk_wr_tog_reg  <= !lk_wr_tog_reg;
        end
    end

    // ==========================================================
    // crossing into clk: toggles synchronised, words held stable
    logic rd_tog_s;
    logic wr_tog_s;
    logic rd_tog_reg;
    logic wr_tog_reg;
    logic otr_s;
    logic otr_n_s;
    logic strb_s;
    logic strb_n_s;
    logic loop_disable_n_n_s;

    qsram_sync #(.W(7)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({lk_rd_tog_reg, lk_wr_tog_reg, output_timing_ref,
                   output_timing_ref_n, link_clk, link_clk_n, loop_disable_n}),
        .q       ({rd_tog_s, wr_tog_s, otr_s, otr_n_s, strb_s, strb_n_s, loop_disable_n_n_s})
    );

    wire rd_evt = rd_tog_s ^ rd_tog_reg;
    wire wr_evt = wr_tog_s ^ wr_tog_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_tog_reg <= 1'b0;
            wr_tog_reg <= 1'b0;
        end else begin
            rd_tog_reg <= rd_tog_s;
            wr_tog_reg <= wr_tog_s;
        end
    end

    // ==========================================================
    // single-clock strap caught after reset release
    // both sync stages reset low, so wait for them before sampling the refs
    logic [1:0] strap_wait_reg;
    logic       strap_done_reg;
    logic       single_reg;
    wire        strap_ready  = (strap_wait_reg == 2'(`QSRAM_SYNC_STAGES));
    wire        strap_single = otr_s && otr_n_s;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_wait_reg <= '0;
            strap_done_reg <= 1'b0;
            single_reg     <= 1'b0;
        end else if (!strap_done_reg) begin
            if (strap_ready) begin
                strap_done_reg <= 1'b1;
                single_reg     <= strap_single;
            end else begin
                strap_wait_reg <= strap_wait_reg + 2'(1);
            end
        end
    end
    assign single_clock_mode = single_reg;

    // ==========================================================
    // array and write commit
    qsram_wr_if #(.AW(AW), .DW(DW), .NL(NL)) wr_bus ();
    assign wr_bus.commit  = wr_evt;
    assign wr_bus.addr    = lk_wr_addr_reg;
    assign wr_bus.word0   = lk_w0_reg;
    assign wr_bus.word1   = lk_w1_reg;
    assign wr_bus.lane0_n = lk_l0_reg;
    assign wr_bus.lane1_n = lk_l1_reg;

    logic [DW-1:0] arr_w0;
    logic [DW-1:0] arr_w1;
    logic [AW-1:0] rd_addr_reg;

    qsram_array #(.AW(AW), .DW(DW), .NL(NL)) u_array (
        .clk      (clk),
        .wr       (wr_bus.dst),
        .rd_addr  (rd_addr_reg),
        .rd_word0 (arr_w0),
        .rd_word1 (arr_w1)
    );

    // ==========================================================
    // forwarding: merge a same-cycle commit lane by lane
    function automatic logic [DW-1:0] qsram_merge(
        input logic [DW-1:0] old_w,
        input logic [DW-1:0] new_w,
        input logic [NL-1:0] lane_n
    );
        logic [DW-1:0] r;
        r = old_w;
        for (int l = 0; l < NL; l++) begin
            if (!lane_n[l]) begin
                r[l*`QSRAM_BYTE_W +: `QSRAM_BYTE_W] = new_w[l*`QSRAM_BYTE_W +: `QSRAM_BYTE_W];
            end
        end
        return r;
    endfunction

    // a commit in this clk cycle is not yet visible at the array read
    wire wr_hit_addr = (lk_wr_addr_reg == rd_addr_reg);
    wire fwd_hit     = wr_evt && wr_hit_addr;
    wire [DW-1:0] fresh_w0 = fwd_hit ? qsram_merge(arr_w0, lk_w0_reg, lk_l0_reg) : arr_w0;
    wire [DW-1:0] fresh_w1 = fwd_hit ? qsram_merge(arr_w1, lk_w1_reg, lk_l1_reg) : arr_w1;

    // ==========================================================
    // read burst sequencer
    qsram_rd_state_type rd_state_reg;
    qsram_rd_state_type rd_state_next;
    logic [DW-1:0]      out_reg;
    logic [DW-1:0]      out_next;
    logic [DW-1:0]      hold1_reg;
    logic [DW-1:0]      hold1_next;
    logic               oe_n_reg;
    logic               oe_n_next;
    // a read landing mid-burst is dropped so the burst address stays put
    wire rd_take = rd_evt && (rd_state_reg == QSRAM_RD_IDLE || rd_state_reg == QSRAM_RD_WORD1);

    always_comb begin
        rd_state_next = rd_state_reg;
        out_next      = out_reg;
        hold1_next    = hold1_reg;
        oe_n_next     = oe_n_reg;
        case (rd_state_reg)
            QSRAM_RD_IDLE: begin
                oe_n_next = 1'b1;
                if (rd_take) begin
                    rd_state_next = QSRAM_RD_WAIT;
                end
            end
            QSRAM_RD_WAIT: begin
                // array read after any commit of this cycle
                rd_state_next = QSRAM_RD_WORD0;
                out_next      = fresh_w0;
                hold1_next    = fresh_w1;
                oe_n_next     = 1'b0;
            end
            QSRAM_RD_WORD0: begin
                rd_state_next = QSRAM_RD_WORD1;
                out_next      = fwd_hit ? fresh_w1 : hold1_reg;
            end
            QSRAM_RD_WORD1: begin
                oe_n_next     = 1'b1;
                rd_state_next = rd_take ? QSRAM_RD_WAIT : QSRAM_RD_IDLE;
            end
            default: begin
                rd_state_next = QSRAM_RD_IDLE;
                oe_n_next     = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_state_reg <= QSRAM_RD_IDLE;
            out_reg      <= '0;
            hold1_reg    <= '0;
            oe_n_reg     <= 1'b1;
            rd_addr_reg  <= '0;
        end else begin
            rd_state_reg <= rd_state_next;
            out_reg      <= out_next;
            hold1_reg    <= hold1_next;
            oe_n_reg     <= oe_n_next;
            if (rd_take) begin
                rd_addr_reg <= lk_rd_addr_reg;
            end
        end
    end

    assign read_data_out  = out_reg;
    assign read_data_oe_n = oe_n_reg;

    // ==========================================================
    // returned strobes follow the active timing pair
    logic cq_reg;
    logic cq_n_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cq_reg   <= 1'b0;
            cq_n_reg <= 1'b0;
        end else begin
            cq_reg   <= single_reg ? strb_s : otr_s;
            cq_n_reg <= single_reg ? strb_n_s : otr_n_s;
        end
    end
    assign returned_strobe   = cq_reg;
    assign returned_strobe_n = cq_n_reg;

    // ==========================================================
    // periodic impedance update and loop status
    // the counter wraps at CAL so the pulse period follows the parameter for CAL up to 1024 (QSRAM_CNT_W is 10 bits)
    logic [`QSRAM_CNT_W-1:0] cal_cnt_reg;
    logic                    cal_reg;
    logic [7:0]              slow_cnt_reg;
    logic                    strb_d_reg;
    logic                    loop_reg;
    wire strb_rise = strb_s && !strb_d_reg;
    wire cal_wrap  = (cal_cnt_reg == `QSRAM_CNT_W'(CAL - 1));
    wire slow_full = (slow_cnt_reg == 8'hFF);
    wire strb_fast = (slow_cnt_reg <= 8'(`QSRAM_DLL_MAX_CYC));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_cnt_reg  <= '0;
            cal_reg      <= 1'b0;
            slow_cnt_reg <= '0;
            strb_d_reg   <= 1'b0;
            loop_reg     <= 1'b0;
        end else begin
            cal_reg     <= cal_wrap;
            if (cal_wrap) begin
                cal_cnt_reg <= '0;
            end else begin
                cal_cnt_reg <= cal_cnt_reg + `QSRAM_CNT_W'(1);
            end
            strb_d_reg  <= strb_s;
            if (strb_rise) begin
                slow_cnt_reg <= '0;
            end else if (!slow_full) begin
                slow_cnt_reg <= slow_cnt_reg + 8'h01;
            end
            // off by pin, or reset while strobe period exceeds limit
            loop_reg <= loop_disable_n_n_s && strb_fast;
        end
    end
    assign impedance_update = cal_reg;
    assign loop_active      = loop_reg;

    // no read or write activity without strobe edges on the link side; calibration runs on clk alone, loop status drops once strobe edges stop
endmodule
`default_nettype wire

// >>> design/qsram_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two flip-flop level synchroniser
module qsram_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// >>> design/qsram_wr_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// committed write to the array
interface qsram_wr_if #(
    parameter int AW = 19,
    parameter int DW = 18,
    parameter int NL = 2
);
    logic          commit;
    logic [AW-1:0] addr;
    logic [DW-1:0] word0;
    logic [DW-1:0] word1;
    logic [NL-1:0] lane0_n;
    logic [NL-1:0] lane1_n;
    modport src (output commit, addr, word0, word1, lane0_n, lane1_n);
    modport dst (input commit, addr, word0, word1, lane0_n, lane1_n);
endinterface
`default_nettype wire

// >>> verification/qsram_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// controller side of the link
module qsram_ctrl_model #(
    parameter int AW = 4,
    parameter int DW = 18,
    parameter int NL = 2
) (
    output logic          link_clk,
    output logic          link_clk_n,
    output logic          read_port_select_n,
    output logic          write_port_select_n,
    output logic [AW-1:0] address_in,
    output logic [DW-1:0] write_value_in,
    output logic [NL-1:0] byte_write_select_n
);
    assign link_clk_n = ~link_clk;
    initial begin
        link_clk = 1'h0;
        read_port_select_n = 1'h1;
        write_port_select_n = 1'h1;
        address_in = '0;
        write_value_in = '0;
        byte_write_select_n = '1;
        #7;
        forever #16 link_clk = ~link_clk;
    end

    task automatic op(input logic rd, input logic wr, input logic [AW-1:0] ra,
                      input logic [AW-1:0] wa, input logic [DW-1:0] w0,
                      input logic [DW-1:0] w1, input logic [NL-1:0] b0,
                      input logic [NL-1:0] b1, input int gap);
        read_port_select_n = ~rd;
        write_port_select_n = ~wr;
        address_in = ra;
        write_value_in = w0;
        byte_write_select_n = b0;
        @(posedge link_clk);
        #1;
        address_in = wa;
        write_value_in = w1;
        byte_write_select_n = b1;
        @(posedge link_clk_n);
        #1;
        for (int i = 0; i < gap; i++) begin
            read_port_select_n = 1'h1;
            write_port_select_n = 1'h1;
            address_in = ~address_in;
            write_value_in = ~write_value_in;
            byte_write_select_n = ~byte_write_select_n;
            @(posedge link_clk_n);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// >>> verification/qsram_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checker
module qsram_port_asserts #(
    parameter int CAL = 1024
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic read_port_select_n,
    input wire logic loop_disable_n,
    input wire logic read_data_oe_n,
    input wire logic single_clock_mode,
    input wire logic loop_active,
    input wire logic impedance_update
);
    logic [3:0]  idle_reg;
    logic [15:0] cal_reg;
    logic        seen_reg;

    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) idle_reg <= 4'h0;
        else if (!read_port_select_n) idle_reg <= 4'h0;
        else if (idle_reg != 4'hf) idle_reg <= idle_reg + 4'h1;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cal_reg <= 16'h0000;
        else if (impedance_update) cal_reg <= 16'h0000;
        else cal_reg <= cal_reg + 16'h0001;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) seen_reg <= 1'h0;
        else if (impedance_update) seen_reg <= 1'h1;
    end

    sequence two_words_s;
        !read_data_oe_n ##1 !read_data_oe_n;
    endsequence
    sequence float_s;
        read_data_oe_n;
    endsequence

    chk_burst_two_words: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(read_data_oe_n) |-> two_words_s ##1 float_s) else $error("burst length wrong");
    chk_reset_float: assert property (@(posedge clk)
        !reset_n |-> read_data_oe_n && !impedance_update) else $error("output not idle");
    chk_cal_period: assert property (@(posedge clk) disable iff (!reset_n)
        seen_reg |-> cal_reg < CAL) else $error("calibration late");
    chk_cal_exact: assert property (@(posedge clk) disable iff (!reset_n)
        impedance_update && seen_reg |-> cal_reg == CAL - 1) else $error("calibration early");
    chk_loop_off: assert property (@(posedge clk) disable iff (!reset_n)
        !loop_disable_n [*5] |-> !loop_active) else $error("loop still active");
    chk_strap_hold: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n, 4) |-> $stable(single_clock_mode)) else $error("strap changed");
    chk_idle_float: assert property (@(posedge clk) disable iff (!reset_n)
        idle_reg >= 4'hc |-> read_data_oe_n) else $error("output driven while idle");
    chk_read_answer: assert property (@(posedge link_clk) disable iff (!reset_n)
        !read_port_select_n |-> ##[2:12] !read_data_oe_n) else $error("read not answered");
endmodule
`default_nettype wire

// >>> verification/quad_rate_sram_port_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ============================================================
// bench top
module quad_rate_sram_port_logic_tb;
    import qsram_pkg::*;
    localparam int AW  = 4;
    localparam int DW  = 18;
    localparam int NL  = 2;
    localparam int CAL = 16;
    logic          clk = 1'h0;
    logic          reset_n = 1'h1;
    logic          output_timing_ref = 1'h1;
    logic          output_timing_ref_n = 1'h1;
    logic          loop_disable_n = 1'h1;
    logic          link_clk;
    logic          link_clk_n;
    logic          read_port_select_n;
    logic          write_port_select_n;
    logic [AW-1:0] address_in;
    logic [DW-1:0] write_value_in;
    logic [NL-1:0] byte_write_select_n;
    logic [DW-1:0] read_data_out;
    logic          read_data_oe_n;
    logic          returned_strobe;
    logic          returned_strobe_n;
    logic          single_clock_mode;
    logic          loop_active;
    logic          impedance_update;
    logic          rs_last = 1'h0;
    logic [DW-1:0] exp_w;
    logic [DW-1:0] mem0 [2**AW];
    logic [DW-1:0] mem1 [2**AW];
    logic [DW-1:0] exp_q [$];
    logic [31:0]   seed = 32'hc56c_b8e1;
    int            error_cnt = 0;
    int            n_checks = 0;
    int            cyc = 0;
    int            pulses = 0;
    int            flips = 0;

    qsram_port #(.AW(AW), .DW(DW), .NL(NL), .CAL(CAL)) u_dut (
        .clk, .reset_n, .link_clk, .link_clk_n, .output_timing_ref, .output_timing_ref_n,
        .read_port_select_n, .write_port_select_n, .address_in, .write_value_in,
        .byte_write_select_n, .loop_disable_n, .read_data_out, .read_data_oe_n,
        .returned_strobe, .returned_strobe_n, .single_clock_mode, .loop_active,
        .impedance_update
    );
    qsram_ctrl_model #(.AW(AW), .DW(DW), .NL(NL)) u_ctl (
        .link_clk, .link_clk_n, .read_port_select_n, .write_port_select_n, .address_in,
        .write_value_in, .byte_write_select_n
    );

    initial begin
        forever #20 clk = ~clk;
    end

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n,
                                  input logic [NL-1:0] b);
        return {b[1] ? o[17:9] : n[17:9], b[0] ? o[8:0] : n[8:0]};
    endfunction

    task automatic acc(input int rd, input int wr, input int ra, input int wa,
                       input int b0, input int b1, input int gap);
        logic [DW-1:0] w0;
        logic [DW-1:0] w1;
        logic [AW-1:0] r;
        logic [AW-1:0] w;
        w0 = DW'(rnd());
        w1 = DW'(rnd());
        r = AW'(ra);
        w = AW'(wa);
        if (wr != 0) begin
            mem0[w] = merge(mem0[w], w0, NL'(b0));
            mem1[w] = merge(mem1[w], w1, NL'(b1));
        end
        if (rd != 0) begin
            exp_q.push_back(mem0[r]);
            exp_q.push_back(mem1[r]);
        end
        u_ctl.op(rd != 0, wr != 0, r, w, w0, w1, NL'(b0), NL'(b1), gap);
    endtask

    task rst();
        @(posedge clk);
        reset_n <= 1'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK(read_data_oe_n, 1'h1)
        @(posedge clk);
        reset_n <= 1'h1;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask

    task drain();
        for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(posedge clk);
        `CHK(exp_q.size(), 0)
    endtask

    task test_done();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(negedge clk) begin
        cyc++;
        if (returned_strobe !== rs_last) flips++;
        rs_last = returned_strobe;
        if (impedance_update === 1'h1) pulses++;
        if (reset_n === 1'h1 && read_data_oe_n === 1'h0) begin
            if (exp_q.size() == 0) `CHK(read_data_oe_n, 1'h1)
            else begin
                exp_w = exp_q.pop_front();
                `CHK(read_data_out, exp_w)
            end
        end
        if (cyc == 3000) begin
            error_cnt++;
            test_done();
        end
    end

    initial begin
        logic [AW-1:0] fa;
        reset_n <= 1'h0;
        rst();
        `CHK(single_clock_mode, 1'h1)
        @(posedge link_clk_n);
        #1;
        for (int a = 0; a < 2**AW; a++) acc(0, 1, 0, a, 0, 0, 5);
        $display("test fill done");
        for (int a = 0; a < 2**AW; a++) acc(1, 1, a, a ^ 8, rnd() % 4, rnd() % 4, 5);
        $display("test concurrent done");
        for (int m = 0; m < 16; m++) begin
            acc(0, 1, 0, m, m % 4, m / 4, 5);
            acc(1, 0, m, 0, 0, 0, 5);
        end
        $display("test byte lanes done");
        for (int i = 0; i < 6; i++) begin
            fa = AW'(rnd());
            acc(0, 1, 0, fa, 0, 0, 0);
            acc(1, 0, fa, 0, 0, 0, 5);
        end
        $display("test forward done");
        acc(0, 0, 0, 0, 0, 0, 30);
        for (int a = 0; a < 4; a++) acc(1, 0, a, 0, 0, 0, 5);
        drain();
        $display("test deselect done");
        @(posedge clk);
        loop_disable_n <= 1'h0;
        repeat (6) @(negedge clk);
        `CHK(loop_active, 1'h0)
        @(posedge clk);
        loop_disable_n <= 1'h1;
        $display("test loop done");
        @(posedge clk);
        pulses = 0;
        repeat (4 * CAL) @(posedge clk);
        #1;
        `CHK(pulses, 4)
        $display("test calibration done");
        @(posedge clk);
        output_timing_ref_n <= 1'h0;
        rst();
        `CHK(single_clock_mode, 1'h0)
        `CHK(returned_strobe_n, 1'h0)
        `CHK(returned_strobe, 1'h1)
        `CHK(flips > 20, 1'h1)
        $display("test reset done");
        test_done();
    end
endmodule

bind qsram_port qsram_port_asserts #(.CAL(CAL)) u_chk (
    .clk, .reset_n, .link_clk, .read_port_select_n, .loop_disable_n, .read_data_oe_n,
    .single_clock_mode, .loop_active, .impedance_update
);
`default_nettype wire
